// [rtl/pcr_pkg.sv]
package pcr_pkg;
   // register addresses on the special-function bus
   localparam logic [7:0] ADDR_PREDIV = 8'ha9;
   localparam logic [7:0] ADDR_MULT = 8'hb1;
   localparam logic [7:0] ADDR_FILTER = 8'hb2;
   localparam logic [7:0] ADDR_CTRL = 8'hb3;
   // reset values
   localparam logic [7:0] RST_PREDIV = 8'h01;
   localparam logic [7:0] RST_MULT = 8'h01;
   localparam logic [7:0] RST_FILTER = 8'h31;
   localparam logic [7:0] RST_CTRL = 8'h00;
   // control field positions
   localparam int CTRL_BIAS_BIT = 0;
   localparam int CTRL_ENABLE_BIT = 1;
   localparam int CTRL_SOURCE_BIT = 2;
   localparam int CTRL_RSVD_BIT = 3;
   localparam int CTRL_LOCK_BIT = 4;
   // filter field positions and widths
   localparam int FILT_LOOP_LSB = 0;
   localparam int LOOP_FILT_W = 4;
   localparam int FILT_OSC_LSB = 4;
   localparam int OSC_RANGE_W = 2;
   // writable masks
   localparam logic [7:0] MASK_CTRL = 8'h07;
   localparam logic [7:0] MASK_PREDIV = 8'h1f;
   localparam logic [7:0] MASK_FILTER = 8'h3f;
   localparam logic [7:0] MASK_MULT = 8'hff;
   // field widths and zero-code factors
   localparam int PREDIV_W = 5;
   localparam int MULT_W = 8;
   localparam logic [5:0] PREDIV_ZERO_FACTOR = 6'h20;
   localparam logic [8:0] MULT_ZERO_FACTOR = 9'h100;
   // lock sequencer states
   typedef enum logic [2:0] {
      PCR_OFF = 3'b001,
      PCR_ACQUIRE = 3'b010,
      PCR_LOCKED = 3'b100
   } pcr_lock_state_t;
endpackage

// [rtl/pcr_cfg_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface pcr_cfg_if;
   logic loop_run;
   logic analog_lock;
   logic lock_flag;
   modport ctrl (output loop_run, output analog_lock, input lock_flag);
   modport seq (input loop_run, input analog_lock, output lock_flag);
endinterface
`default_nettype wire

// [rtl/pcr_lock_seq.sv]
`timescale 1ns/1ns
`default_nettype none
module pcr_lock_seq (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // control side
   pcr_cfg_if.seq cfg
);
   pcr_pkg::pcr_lock_state_t state_reg, state_next;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         pcr_pkg::PCR_OFF: begin
            if (cfg.loop_run) begin
               state_next = pcr_pkg::PCR_ACQUIRE;
            end
         end
         pcr_pkg::PCR_ACQUIRE: begin
            if (!cfg.loop_run) begin
               state_next = pcr_pkg::PCR_OFF;
            end else if (cfg.analog_lock) begin
               state_next = pcr_pkg::PCR_LOCKED;
            end
         end
         pcr_pkg::PCR_LOCKED: begin
            if (!cfg.loop_run) begin
               state_next = pcr_pkg::PCR_OFF;
            end else if (!cfg.analog_lock) begin
               state_next = pcr_pkg::PCR_ACQUIRE;
            end
         end
         default: state_next = pcr_pkg::PCR_OFF;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_reg <= pcr_pkg::PCR_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign cfg.lock_flag = (state_reg == pcr_pkg::PCR_LOCKED) && cfg.loop_run;
endmodule // pcr_lock_seq
`default_nettype wire

// [rtl/pcr_regs.sv]
// Operation
// - control bit 4 reads lock flag, read-only, 1 when locked
// - control bit 3 reserved, reads zero, software writes zero
// - control bit 2 selects reference: 0 internal, 1 external oscillator
// - loop enable 0 holds loop logic in reset
// - control bit 0 gates bias generator; required for operation
// - control bits 7..5 read zero, writes ignored
// - pre-divider low five bits give divide ratio
// - pre-divider zero divides by thirty-two
// - pre-divider bits 7..5 read zero, writes ignored
// - multiplier eight bits give multiplication factor
// - multiplier zero means factor 256
// - filter bits 7..6 read zero, writes ignored
// - output frequency equals reference times multiplier over pre-divider
`timescale 1ns/1ns
`default_nettype none
module pcr_regs #(
   parameter int PREDIV_W = pcr_pkg::PREDIV_W,
   parameter int MULT_W = pcr_pkg::MULT_W
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // special-function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   // analog loop
   input wire logic analog_lock_pin,
   output logic bias_power_enable,
   output logic loop_run,
   output logic reference_source_select,
   output logic [5:0] predivide_factor,
   output logic [8:0] multiplier_factor,
   output logic [1:0] oscillator_range,
   output logic [3:0] loop_filter_range,
   output logic lock_flag
);
   ////////////////////////////////////////////////////////////////////////
   // elaboration checks
   if (PREDIV_W != pcr_pkg::PREDIV_W) begin : g_bad_prediv_w
      $error("pcr_regs: pre-divider width is fixed by the register layout");
   end
   if (MULT_W != pcr_pkg::MULT_W) begin : g_bad_mult_w
      $error("pcr_regs: multiplier width is fixed by the register layout");
   end
   if (int'(pcr_pkg::MASK_PREDIV) != (1 << PREDIV_W) - 1) begin : g_bad_prediv_mask
      $error("pcr_regs: pre-divider mask does not match its width");
   end
   if (int'(pcr_pkg::MASK_MULT) != (1 << MULT_W) - 1) begin : g_bad_mult_mask
      $error("pcr_regs: multiplier mask does not match its width");
   end
   if (int'(pcr_pkg::PREDIV_ZERO_FACTOR) != (1 << PREDIV_W)) begin : g_bad_prediv_zero
      $error("pcr_regs: pre-divider zero factor does not match its width");
   end
   if (int'(pcr_pkg::MULT_ZERO_FACTOR) != (1 << MULT_W)) begin : g_bad_mult_zero
      $error("pcr_regs: multiplier zero factor does not match its width");
   end

   ////////////////////////////////////////////////////////////////////////
   // register storage
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] prediv_reg;
   logic [7:0] prediv_next;
   logic [7:0] mult_reg;
   logic [7:0] mult_next;
   logic [7:0] filter_reg;
   logic [7:0] filter_next;
   // write strobes
   logic wr_ctrl;
   logic wr_prediv;
   logic wr_mult;
   logic wr_filter;
   // lock synchroniser
   logic lock_meta_reg;
   logic lock_meta_next;
   logic lock_sync_reg;
   logic lock_sync_next;
   // read path
   logic [7:0] ctrl_view;
   logic [7:0] prediv_view;
   logic [7:0] mult_view;
   logic [7:0] filter_view;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   // zero-code factors before trimming
   logic [8:0] prediv_factor_full;
   logic [8:0] mult_factor_full;

   ////////////////////////////////////////////////////////////////////////
   // link to the lock sequencer
   pcr_cfg_if cfg ();

   ////////////////////////////////////////////////////////////////////////
   // helper functions
   function automatic logic addr_match(input logic [7:0] addr, input logic [7:0] target);
      addr_match = (addr == target);
   endfunction

   function automatic logic addr_mapped(input logic [7:0] addr);
      addr_mapped = addr_match(addr, pcr_pkg::ADDR_CTRL)
         || addr_match(addr, pcr_pkg::ADDR_PREDIV)
         || addr_match(addr, pcr_pkg::ADDR_MULT)
         || addr_match(addr, pcr_pkg::ADDR_FILTER);
   endfunction

   function automatic logic [7:0] masked_write(input logic [7:0] v, input logic [7:0] m);
      masked_write = v & m;
   endfunction

   // a zero field selects the full-range factor
   function automatic logic [8:0] zero_code_factor(input logic [7:0] field,
      input logic [8:0] full_range);
      if (field == '0) begin
         zero_code_factor = full_range;
      end else begin
         zero_code_factor = {1'b0, field};
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // write decode
   always_comb begin
      wr_ctrl = sfr_wr && addr_match(sfr_addr, pcr_pkg::ADDR_CTRL);
      wr_prediv = sfr_wr && addr_match(sfr_addr, pcr_pkg::ADDR_PREDIV);
      wr_mult = sfr_wr && addr_match(sfr_addr, pcr_pkg::ADDR_MULT);
      wr_filter = sfr_wr && addr_match(sfr_addr, pcr_pkg::ADDR_FILTER);
   end

   ////////////////////////////////////////////////////////////////////////
   // control register
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = masked_write(sfr_wdata, pcr_pkg::MASK_CTRL);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_reg <= pcr_pkg::RST_CTRL;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pre-divider register
   always_comb begin
      prediv_next = prediv_reg;
      if (wr_prediv) begin
         prediv_next = masked_write(sfr_wdata, pcr_pkg::MASK_PREDIV);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         prediv_reg <= pcr_pkg::RST_PREDIV;
      end else begin
         prediv_reg <= prediv_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // multiplier register
   always_comb begin
      mult_next = mult_reg;
      if (wr_mult) begin
         mult_next = masked_write(sfr_wdata, pcr_pkg::MASK_MULT);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         mult_reg <= pcr_pkg::RST_MULT;
      end else begin
         mult_reg <= mult_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // filter register
   always_comb begin
      filter_next = filter_reg;
      if (wr_filter) begin
         filter_next = masked_write(sfr_wdata, pcr_pkg::MASK_FILTER);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         filter_reg <= pcr_pkg::RST_FILTER;
      end else begin
         filter_reg <= filter_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // lock input synchroniser
   always_comb begin
      lock_meta_next = analog_lock_pin;
      lock_sync_next = lock_meta_reg;
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         lock_meta_reg <= 1'b0;
         lock_sync_reg <= 1'b0;
      end else begin
         lock_meta_reg <= lock_meta_next;
         lock_sync_reg <= lock_sync_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data
   always_comb begin
      ctrl_view = ctrl_reg & pcr_pkg::MASK_CTRL;
      ctrl_view[pcr_pkg::CTRL_RSVD_BIT] = 1'b0;
      ctrl_view[pcr_pkg::CTRL_LOCK_BIT] = cfg.lock_flag;
      prediv_view = prediv_reg & pcr_pkg::MASK_PREDIV;
      mult_view = mult_reg & pcr_pkg::MASK_MULT;
      filter_view = filter_reg & pcr_pkg::MASK_FILTER;
   end

   always_comb begin
      rdata_next = rdata_reg;
      if (sfr_rd) begin
         unique case (sfr_addr)
            pcr_pkg::ADDR_CTRL: begin
               rdata_next = ctrl_view;
            end
            pcr_pkg::ADDR_PREDIV: begin
               rdata_next = prediv_view;
            end
            pcr_pkg::ADDR_MULT: begin
               rdata_next = mult_view;
            end
            pcr_pkg::ADDR_FILTER: begin
               rdata_next = filter_view;
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port outputs
   assign sfr_rdata = rdata_reg;
   assign sfr_hit = addr_mapped(sfr_addr);

   ////////////////////////////////////////////////////////////////////////
   // loop control outputs
   assign bias_power_enable = ctrl_reg[pcr_pkg::CTRL_BIAS_BIT];
   assign reference_source_select = ctrl_reg[pcr_pkg::CTRL_SOURCE_BIT];
   // bias must be on as well, so enable alone keeps the loop in reset
   assign loop_run = ctrl_reg[pcr_pkg::CTRL_ENABLE_BIT]
      && ctrl_reg[pcr_pkg::CTRL_BIAS_BIT];

   ////////////////////////////////////////////////////////////////////////
   // divide and multiply factors
   assign prediv_factor_full = zero_code_factor(prediv_view,
      {3'h0, pcr_pkg::PREDIV_ZERO_FACTOR});
   assign mult_factor_full = zero_code_factor(mult_view,
      pcr_pkg::MULT_ZERO_FACTOR);
   assign predivide_factor = prediv_factor_full[PREDIV_W:0];
   assign multiplier_factor = mult_factor_full[MULT_W:0];

   ////////////////////////////////////////////////////////////////////////
   // filter range outputs
   assign oscillator_range = filter_reg[pcr_pkg::FILT_OSC_LSB +: pcr_pkg::OSC_RANGE_W];
   assign loop_filter_range = filter_reg[pcr_pkg::FILT_LOOP_LSB +: pcr_pkg::LOOP_FILT_W];

   ////////////////////////////////////////////////////////////////////////
   // lock sequencer
   assign cfg.loop_run = loop_run;
   assign cfg.analog_lock = lock_sync_reg;
   assign lock_flag = cfg.lock_flag;

   pcr_lock_seq u_lock_seq (
      .core_clk(core_clk),
      .srst(srst),
      .cfg(cfg)
   );
endmodule // pcr_regs
`default_nettype wire

// [sim/pcr_regs_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module pcr_regs_sva #(
   parameter int PREDIV_W = 5,
   parameter int MULT_W = 8
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic srst,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic sfr_hit,
   // loop side
   input wire logic analog_lock_pin,
   input wire logic bias_power_enable,
   input wire logic loop_run,
   input wire logic reference_source_select,
   input wire logic [5:0] predivide_factor,
   input wire logic [8:0] multiplier_factor,
   input wire logic [1:0] oscillator_range,
   input wire logic [3:0] loop_filter_range,
   input wire logic lock_flag
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////////
   ctrl_write_a: assert property (sfr_wr && sfr_addr == 8'hb3 |=>
      bias_power_enable == $past(sfr_wdata[0]) && loop_run == &$past(sfr_wdata[1:0])
      && reference_source_select == $past(sfr_wdata[2])) else $error("control write");
   run_gate_a: assert property (!bias_power_enable |-> !loop_run) else $error("run");
   lock_hold_a: assert property (!loop_run |-> !lock_flag) else $error("lock hold");
   lock_set_a: assert property ((loop_run && analog_lock_pin) [*5] |-> lock_flag)
      else $error("lock set");
   div_write_a: assert property (sfr_wr && sfr_addr == 8'ha9 |=> predivide_factor ==
      ($past(sfr_wdata[4:0]) == 5'h00 ? 6'h20 : {1'b0, $past(sfr_wdata[4:0])}))
      else $error("divider");
   mul_write_a: assert property (sfr_wr && sfr_addr == 8'hb1 |=> multiplier_factor ==
      ($past(sfr_wdata) == 8'h00 ? 9'h100 : {1'b0, $past(sfr_wdata)})) else $error("mult");
   filt_write_a: assert property (sfr_wr && sfr_addr == 8'hb2 |=>
      {oscillator_range, loop_filter_range} == $past(sfr_wdata[5:0])) else $error("filter");
   ctrl_read_a: assert property (sfr_rd && sfr_addr == 8'hb3 |=>
      sfr_rdata[7:5] == 3'h0 && !sfr_rdata[3] && sfr_rdata[4] == $past(lock_flag)
      && sfr_rdata[0] == $past(bias_power_enable)) else $error("control read");
   div_read_a: assert property (sfr_rd && sfr_addr == 8'ha9 |=> sfr_rdata[7:5] == 3'h0)
      else $error("divider read");
   miss_read_a: assert property (sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("miss");
endmodule // pcr_regs_sva
bind pcr_regs pcr_regs_sva #(.PREDIV_W(PREDIV_W), .MULT_W(MULT_W)) u_pcr_sva (.*);
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic core_clk, srst, sfr_wr, sfr_rd, analog_lock_pin, sfr_hit, bias_power_enable;
   logic loop_run, reference_source_select, lock_flag;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [5:0] predivide_factor;
   logic [8:0] multiplier_factor, q;
   logic [1:0] oscillator_range;
   logic [3:0] loop_filter_range;
   int n_fail = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [7:0] ra [4] = '{8'ha9, 8'hb1, 8'hb2, 8'hb3};
   logic [7:0] rv [4] = '{8'h01, 8'h01, 8'h31, 8'h00};
   // address, write data, read back
   logic [7:0] rows [10][3] = '{'{8'ha9, 8'hff, 8'h1f}, '{8'ha9, 8'h00, 8'h00},
      '{8'hb1, 8'h00, 8'h00}, '{8'hb1, 8'ha5, 8'ha5}, '{8'hb2, 8'hff, 8'h3f},
      '{8'hb2, 8'hc1, 8'h01}, '{8'hb3, 8'he5, 8'h05}, '{8'hb3, 8'hf0, 8'h00},
      '{8'hb3, 8'h04, 8'h04}, '{8'h7e, 8'hff, 8'h00}};
   pcr_regs DUT (.*);
   ////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         $display("mismatch %0t timeout", $time);
         report_and_stop();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge core_clk);
      #1 sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      #1 sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge core_clk);
      #1 sfr_rd = 1'b0;
      q = {1'b0, sfr_rdata};
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      {sfr_wr, sfr_rd, analog_lock_pin, sfr_addr, sfr_wdata} = '0;
      srst = 1'b1;
      repeat (8) @(posedge core_clk);
      #1 srst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(ra[i]);
         chk(q, {1'b0, rv[i]});
      end
      chk({oscillator_range, loop_filter_range, predivide_factor[2:0]}, 9'h189);
      $display("test reset done");
      foreach (rows[i]) begin
         wr(rows[i][0], rows[i][1]);
         rd(rows[i][0]);
         chk(q, {1'b0, rows[i][2]});
         chk(sfr_hit, rows[i][0] != 8'h7e);
      end
      $display("test table done");
      wr(8'ha9, 8'h00);
      wr(8'hb1, 8'h00);
      chk({predivide_factor, 3'h0}, 9'h100);
      chk(multiplier_factor, 9'h100);
      // 25 MHz reference assumed: divided to 5 MHz, multiplied to 40 MHz
      wr(8'hb3, 8'h01);
      wr(8'ha9, 8'h05);
      wr(8'hb2, 8'h2f);
      wr(8'hb1, 8'h08);
      chk({predivide_factor, 3'h0}, 9'h028);
      chk(multiplier_factor, 9'h008);
      analog_lock_pin = 1'b1;
      repeat (626) @(posedge core_clk);
      #1 chk({bias_power_enable, loop_run, lock_flag}, 9'h004);
      wr(8'hb3, 8'h03);
      q = '0;
      for (int i = 0; i < 8 && !q[4]; i++) rd(8'hb3);
      chk(q, 9'h013);
      wr(8'hb3, 8'h05);
      chk({bias_power_enable, loop_run, lock_flag, reference_source_select}, 9'h009);
      rd(8'hb3);
      chk(q, 9'h005);
      $display("test lock done");
      srst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 srst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(ra[i]);
         chk(q, {1'b0, rv[i]});
      end
      chk({bias_power_enable, loop_run, lock_flag, multiplier_factor[2:0]}, 9'h001);
      $display("test mid reset done");
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
